// [src/aaa_alu.v]
`timescale 1ns/1ns
`default_nettype none
`include "aaa_exec_map.vh"
// Add-with-carry and AND datapath
module aaa_alu (
    // Operands
    input wire [7:0] accIn,
    input wire [7:0] srcIn,
    input wire carryIn,
    // Results
    output wire [7:0] sumOut,
    output wire carryOut,
    output wire auxOut,
    output wire ovfOut,
    output wire [7:0] andOut
);
    wire [4:0] lowSum;
    wire [3:0] midSum;
    wire [1:0] topSum;
    // Split adder exposes carries out of bits 3, 6 and 7
    assign lowSum = {1'b0, accIn[3:0]} + {1'b0, srcIn[3:0]} + {4'h0, carryIn};
    assign midSum = {1'b0, accIn[6:4]} + {1'b0, srcIn[6:4]} + {3'h0, lowSum[4]};
    assign topSum = {1'b0, accIn[7]} + {1'b0, srcIn[7]} + {1'b0, midSum[3]};
    assign sumOut = {topSum[0], midSum[2:0], lowSum[3:0]};
    assign carryOut = topSum[1];
    assign auxOut = lowSum[4];
    assign ovfOut = topSum[1] ^ midSum[3];
    assign andOut = accIn & srcIn;
endmodule // aaa_alu
`default_nettype wire

// [src/aaa_decode.v]
`timescale 1ns/1ns
`default_nettype none
`include "aaa_exec_map.vh"
// Combinational opcode classifier
module aaa_decode (
    // Opcode
    input wire [7:0] opcode,
    // Classification
    output reg [3:0] kind,
    output reg [1:0] srcSel,
    output reg [1:0] byteCount,
    output reg twoCycle,
    output reg known
);
    // Pattern match
    always @* begin
        kind = `AAA_KIND_NONE;
        srcSel = `AAA_SRC_REG;
        byteCount = 2'h1;
        twoCycle = 1'b0;
        known = 1'b1;
        if ((opcode & `AAA_MSK_REG) == `AAA_OP_ADCY_REG) begin
            kind = `AAA_KIND_ADCY;
        end else if (opcode == `AAA_OP_ADCY_DIR) begin
            kind = `AAA_KIND_ADCY; srcSel = `AAA_SRC_DIR; byteCount = 2'h2;
        end else if ((opcode & `AAA_MSK_IND) == `AAA_OP_ADCY_IND) begin
            kind = `AAA_KIND_ADCY; srcSel = `AAA_SRC_IND;
        end else if (opcode == `AAA_OP_ADCY_IMM) begin
            kind = `AAA_KIND_ADCY; srcSel = `AAA_SRC_IMM; byteCount = 2'h2;
        end else if ((opcode & `AAA_MSK_JUMP) == `AAA_OP_JUMP) begin
            kind = `AAA_KIND_JMP; byteCount = 2'h2; twoCycle = 1'b1;
        end else if ((opcode & `AAA_MSK_REG) == `AAA_OP_AND_REG) begin
            kind = `AAA_KIND_ANDA;
        end else if ((opcode & `AAA_MSK_IND) == `AAA_OP_AND_IND) begin
            kind = `AAA_KIND_ANDA; srcSel = `AAA_SRC_IND;
        end else if (opcode == `AAA_OP_AND_DIR) begin
            kind = `AAA_KIND_ANDA; srcSel = `AAA_SRC_DIR; byteCount = 2'h2;
        end else if (opcode == `AAA_OP_AND_IMM) begin
            kind = `AAA_KIND_ANDA; srcSel = `AAA_SRC_IMM; byteCount = 2'h2;
        end else if (opcode == `AAA_OP_ANDD_A) begin
            kind = `AAA_KIND_ANDD; srcSel = `AAA_SRC_DIR; byteCount = 2'h2;
        end else if (opcode == `AAA_OP_ANDD_IMM) begin
            kind = `AAA_KIND_ANDD; srcSel = `AAA_SRC_IMM; byteCount = 2'h3;
            twoCycle = 1'b1;
        end else begin
            known = 1'b0;
        end
    end
endmodule // aaa_decode
`default_nettype wire

// [src/aaa_exec.v]
`timescale 1ns/1ns
`default_nettype none
`include "aaa_exec_map.vh"
// Function
// - add_with_carry_op writes accumulator plus source plus carry into accumulator
// - Carry is carry out of bit 7, aux_carry_flag out of bit 3
// - overflow_flag set when exactly one of carries out of bits 6, 7
// - Add source is register, direct, indirect or immediate
// - Direct add is 0x35 plus address, two bytes, one cycle
// - Indirect add is 0011011i, pointer selected by bit 0, one byte
// - Immediate add is 0x34 plus constant, two bytes, one cycle
// - Jump target: high five bits of PC+2, opcode 7-5, second byte
// - absolute_jump_op is aaa00001, two bytes, two cycles
// - logical_and_op stores AND; only parity changes, and only for accumulator
// - Six AND forms: accumulator or direct destination
// - Direct-destination port AND reads the output latch, not the pins
// - Accumulator AND direct is 0x55, two bytes, one cycle
// - Accumulator AND immediate is 0x54, two bytes, one cycle
// - Direct AND accumulator is 0x52, two bytes, one cycle
// - Direct AND immediate is 0x53, three bytes, two cycles
module aaa_exec (
    // Clock, reset, enable
    input wire clk,
    input wire rst_b,
    input wire clkEn,
    // Instruction bytes from program memory
    input wire instrValid,
    input wire [7:0] opcode,
    input wire [7:0] byte2,
    input wire [7:0] byte3,
    input wire [15:0] pcIn,
    // Operand data from register file and data space
    input wire [7:0] accIn,
    input wire carryIn,
    input wire [7:0] workRegData,
    input wire [7:0] indirectPtrData,
    input wire [7:0] directData,
    input wire [7:0] portLatchData,
    input wire directIsPort,
    // Decoded selects
    output wire [2:0] workingRegisterSel,
    output wire indirectPointerReg,
    output wire [7:0] directAddr,
    // Results
    output reg accWe,
    output reg [7:0] accOut,
    output reg flagWe,
    output reg carryFlag,
    output reg auxCarryFlag,
    output reg overflowFlag,
    output reg parityFlag,
    output reg dirWe,
    output reg [7:0] dirWrAddr,
    output reg [7:0] dirWrData,
    output reg pcWe,
    output reg [15:0] pcOut,
    output reg done,
    output wire busy,
    output reg illegal
);
    localparam ST_IDLE = 1'b0;
    localparam ST_WAIT = 1'b1;
    reg rstSync1, rstSync2;
    reg state;
    reg [15:0] pendPc;
    reg [15:0] pendWrAddr;
    reg [7:0] pendData;
    reg pendKindJmp;
    wire [3:0] kind;
    wire [1:0] srcSel;
    wire [1:0] byteCount;
    wire twoCycle;
    wire known;
    reg [7:0] srcByte;
    reg [7:0] dirOrig;
    wire [7:0] sumVal, andVal, andDirVal;
    wire cOut, acOut, ovOut;
    wire [15:0] pcPlus2;
    wire [15:0] jumpTarget;
    wire [15:0] nextPc;
    // Reset release through two flops
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rstSync1 <= 1'b0;
            rstSync2 <= 1'b0;
        end else begin
            rstSync1 <= 1'b1;
            rstSync2 <= rstSync1;
        end
    end
    aaa_decode uDecode (
        .opcode(opcode),
        .kind(kind),
        .srcSel(srcSel),
        .byteCount(byteCount),
        .twoCycle(twoCycle),
        .known(known)
    );
    // Operand selects from opcode fields and second byte
    assign workingRegisterSel = opcode[2:0];
    assign indirectPointerReg = opcode[0];
    assign directAddr = byte2;
    // Source operand mux
    always @* begin
        case (srcSel)
            `AAA_SRC_REG: srcByte = workRegData;
            `AAA_SRC_DIR: srcByte = directData;
            `AAA_SRC_IND: srcByte = indirectPtrData;
            `AAA_SRC_IMM: srcByte = byte2;
            default: srcByte = workRegData;
        endcase
    end
    // Original destination byte: port latch when target is a port
    always @* begin
        dirOrig = directIsPort ? portLatchData : directData;
    end
    aaa_alu uAlu (
        .accIn(accIn),
        .srcIn(srcByte),
        .carryIn(carryIn),
        .sumOut(sumVal),
        .carryOut(cOut),
        .auxOut(acOut),
        .ovfOut(ovOut),
        .andOut(andVal)
    );
    // Direct-destination mask is accumulator or third byte
    assign andDirVal = dirOrig & ((opcode == `AAA_OP_ANDD_IMM) ? byte3 : accIn);
    // Program counter arithmetic
    assign pcPlus2 = pcIn + `AAA_PC_STEP2;
    assign jumpTarget = {pcPlus2[15:11], opcode[7:5], byte2};
    assign nextPc = (byteCount == 2'h3) ? pcIn + `AAA_PC_STEP3 :
                    (byteCount == 2'h2) ? pcPlus2 : pcIn + `AAA_PC_STEP1;
    assign busy = (state == ST_WAIT);
    // Execution sequencer
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= ST_IDLE;
            accWe <= 1'b0;
            accOut <= 8'h00;
            flagWe <= 1'b0;
            carryFlag <= 1'b0;
            auxCarryFlag <= 1'b0;
            overflowFlag <= 1'b0;
            parityFlag <= 1'b0;
            dirWe <= 1'b0;
            dirWrAddr <= 8'h00;
            dirWrData <= 8'h00;
            pcWe <= 1'b0;
            pcOut <= 16'h0000;
            done <= 1'b0;
            illegal <= 1'b0;
            pendPc <= 16'h0000;
            pendWrAddr <= 16'h0000;
            pendData <= 8'h00;
            pendKindJmp <= 1'b0;
        end else if (!rstSync2) begin
            state <= ST_IDLE;
            accWe <= 1'b0;
            flagWe <= 1'b0;
            dirWe <= 1'b0;
            pcWe <= 1'b0;
            done <= 1'b0;
            illegal <= 1'b0;
        end else if (clkEn) begin
            accWe <= 1'b0;
            flagWe <= 1'b0;
            dirWe <= 1'b0;
            pcWe <= 1'b0;
            done <= 1'b0;
            illegal <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (instrValid && known) begin
                        case (kind)
                            `AAA_KIND_ADCY: begin
                                accWe <= 1'b1;
                                accOut <= sumVal;
                                flagWe <= 1'b1;
                                carryFlag <= cOut;
                                auxCarryFlag <= acOut;
                                overflowFlag <= ovOut;
                                parityFlag <= ^sumVal;
                                pcWe <= 1'b1;
                                pcOut <= nextPc;
                                done <= 1'b1;
                            end
                            `AAA_KIND_ANDA: begin
                                accWe <= 1'b1;
                                accOut <= andVal;
                                parityFlag <= ^andVal;
                                pcWe <= 1'b1;
                                pcOut <= nextPc;
                                done <= 1'b1;
                            end
                            `AAA_KIND_ANDD: begin
                                if (twoCycle) begin
                                    pendWrAddr <= {8'h00, byte2};
                                    pendData <= andDirVal;
                                    pendPc <= nextPc;
                                    pendKindJmp <= 1'b0;
                                    state <= ST_WAIT;
                                end else begin
                                    dirWe <= 1'b1;
                                    dirWrAddr <= byte2;
                                    dirWrData <= andDirVal;
                                    pcWe <= 1'b1;
                                    pcOut <= nextPc;
                                    done <= 1'b1;
                                end
                            end
                            `AAA_KIND_JMP: begin
                                pendPc <= jumpTarget;
                                pendKindJmp <= 1'b1;
                                state <= ST_WAIT;
                            end
                            default: begin
                                illegal <= 1'b1;
                            end
                        endcase
                    end else if (instrValid) begin
                        illegal <= 1'b1;
                    end
                end
                ST_WAIT: begin
                    // Second cycle completes two-cycle forms
                    if (!pendKindJmp) begin
                        dirWe <= 1'b1;
                        dirWrAddr <= pendWrAddr[7:0];
                        dirWrData <= pendData;
                    end
                    pcWe <= 1'b1;
                    pcOut <= pendPc;
                    done <= 1'b1;
                    state <= ST_IDLE;
                end
                default: state <= ST_IDLE;
            endcase
        end
    end
endmodule // aaa_exec
`default_nettype wire

// [src/aaa_exec_map.vh]
`ifndef AAA_EXEC_MAP_VH
`define AAA_EXEC_MAP_VH
// Opcode patterns and masks
`define AAA_OP_ADCY_REG 8'h38
`define AAA_MSK_REG 8'hF8
`define AAA_OP_ADCY_DIR 8'h35
`define AAA_OP_ADCY_IND 8'h36
`define AAA_MSK_IND 8'hFE
`define AAA_OP_ADCY_IMM 8'h34
`define AAA_OP_JUMP 8'h01
`define AAA_MSK_JUMP 8'h1F
`define AAA_OP_AND_REG 8'h58
`define AAA_OP_AND_DIR 8'h55
`define AAA_OP_AND_IND 8'h56
`define AAA_OP_AND_IMM 8'h54
`define AAA_OP_ANDD_A 8'h52
`define AAA_OP_ANDD_IMM 8'h53
// Program counter steps
`define AAA_PC_STEP2 16'h0002
`define AAA_PC_STEP1 16'h0001
`define AAA_PC_STEP3 16'h0003
// Kind codes
`define AAA_KIND_NONE 4'h0
`define AAA_KIND_ADCY 4'h1
`define AAA_KIND_ANDA 4'h2
`define AAA_KIND_ANDD 4'h3
`define AAA_KIND_JMP 4'h4
// Source codes
`define AAA_SRC_REG 2'h0
`define AAA_SRC_DIR 2'h1
`define AAA_SRC_IND 2'h2
`define AAA_SRC_IMM 2'h3
`endif

// [tb/aaa_data_model.sv]
`timescale 1ns/1ns
`default_nettype none
// Data space behind the core: working registers, pointers, direct bytes, ports
module aaa_data_model (
    // Selects from the core
    input wire logic [2:0] workingRegisterSel,
    input wire logic indirectPointerReg,
    input wire logic [7:0] directAddr,
    // Operand bytes
    output logic [7:0] workRegData,
    output logic [7:0] indirectPtrData,
    output logic [7:0] directData,
    output logic [7:0] portLatchData,
    output logic directIsPort
);
    logic [7:0] ram [0:255];
    integer n;
    // Fixed scrambled contents
    initial begin
        for (n = 0; n < 256; n = n + 1) begin
            ram[n] = n[7:0] * 8'h5B ^ 8'hC6;
        end
    end
    // Registers 0 and 1 double as pointers
    assign workRegData = ram[{5'h00, workingRegisterSel}];
    assign indirectPtrData = ram[ram[{7'h00, indirectPointerReg}]];
    // Pins of a port read as the inverse of its latch
    assign directIsPort = directAddr[7] && directAddr[3:0] == 4'h0;
    assign portLatchData = ram[directAddr];
    assign directData = directIsPort ? ~ram[directAddr] : ram[directAddr];
endmodule // aaa_data_model
`default_nettype wire

// [tb/aaa_exec_props.sv]
`timescale 1ns/1ns
`default_nettype none
// Cycle-level checks on the execution core ports
module aaa_exec_props (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Request side
    input wire logic clkEn,
    input wire logic instrValid,
    input wire logic [7:0] opcode,
    input wire logic [7:0] byte2,
    input wire logic [15:0] pcIn,
    input wire logic [7:0] accIn,
    input wire logic carryIn,
    input wire logic [7:0] directData,
    input wire logic [7:0] portLatchData,
    input wire logic directIsPort,
    // Results
    input wire logic accWe,
    input wire logic [7:0] accOut,
    input wire logic flagWe,
    input wire logic carryFlag,
    input wire logic parityFlag,
    input wire logic dirWe,
    input wire logic [7:0] dirWrAddr,
    input wire logic [7:0] dirWrData,
    input wire logic pcWe,
    input wire logic [15:0] pcOut,
    input wire logic done,
    input wire logic busy,
    input wire logic illegal
);
    logic taken;
    logic [15:0] pcNext;
    logic [15:0] capTarget;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    // Request accepted in this cycle
    assign taken = clkEn && instrValid && !busy;
    assign pcNext = pcIn + 16'h0002;
    // Jump target captured when the jump is accepted
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            capTarget <= 16'h0000;
        end else if (taken) begin
            capTarget <= {pcNext[15:11], opcode[7:5], byte2};
        end
    end
    AST_ADD_CARRY_REG_ONE: assert property (taken && opcode[7:3] == 5'b00111 |=> accWe && flagWe && done && !busy)
        else $error("register add did not finish in one cycle");
    AST_ABS_JUMP_TWO: assert property (taken && opcode[4:0] == 5'h01 |=> busy && !pcWe ##1 pcWe && done)
        else $error("jump did not take two cycles");
    AST_ABS_JUMP_TARGET: assert property (taken && opcode[4:0] == 5'h01 |-> ##2 pcOut == capTarget)
        else $error("jump target wrong");
    AST_ANDD_IMM_TWO: assert property (taken && opcode == 8'h53 |=> busy && !dirWe ##1 dirWe && done)
        else $error("direct AND immediate timing wrong");
    AST_PARITY: assert property (accWe |-> parityFlag == ^accOut)
        else $error("parity does not follow accumulator");
    AST_AND_NO_FLAGS: assert property (taken && opcode[7:4] == 4'h5 |=> !flagWe)
        else $error("AND updated arithmetic flags");
    AST_ANDD_LATCH: assert property (taken && opcode == 8'h52 |=> dirWe && dirWrAddr == $past(byte2)
        && dirWrData == $past((directIsPort ? portLatchData : directData) & accIn))
        else $error("direct AND accumulator result wrong");
    AST_ILLEGAL_QUIET: assert property (illegal |-> !accWe && !dirWe && !pcWe)
        else $error("unknown opcode caused a write");
    AST_ADD_CARRY_IMM_SUM: assert property (taken && opcode == 8'h34 |=> accOut == $past(accIn + byte2 + carryIn)
        && carryFlag == $past({1'b0, accIn} + byte2 + carryIn > 9'h0FF))
        else $error("immediate add result or carry wrong");
endmodule // aaa_exec_props
bind aaa_exec aaa_exec_props aaa_exec_props_inst (.clk(clk), .rst_b(rst_b), .clkEn(clkEn),
    .instrValid(instrValid), .opcode(opcode), .byte2(byte2), .pcIn(pcIn), .accIn(accIn),
    .carryIn(carryIn), .directData(directData), .portLatchData(portLatchData),
    .directIsPort(directIsPort), .accWe(accWe), .accOut(accOut), .flagWe(flagWe),
    .carryFlag(carryFlag), .parityFlag(parityFlag), .dirWe(dirWe), .dirWrAddr(dirWrAddr),
    .dirWrData(dirWrData), .pcWe(pcWe), .pcOut(pcOut), .done(done), .busy(busy), .illegal(illegal));
`default_nettype wire

// [tb/aaa_exec_tb_top.sv]
`timescale 1ns/1ns
`default_nettype none
// Random and corner instruction stream against the execution core
module aaa_exec_tb_top;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic clkEn = 1'b1;
    logic instrValid = 1'b0;
    logic [7:0] opcode = 8'h00, byte2 = 8'h00, byte3 = 8'h00, accIn = 8'h00;
    logic [15:0] pcIn = 16'h0000;
    logic carryIn = 1'b0;
    wire [7:0] workRegData, indirectPtrData, directData, portLatchData, directAddr;
    wire [7:0] accOut, dirWrAddr, dirWrData;
    wire [15:0] pcOut;
    wire [2:0] workingRegisterSel;
    wire directIsPort, indirectPointerReg, accWe, flagWe, carryFlag, auxCarryFlag;
    wire overflowFlag, parityFlag, dirWe, pcWe, done, busy, illegal;
    integer err_count = 0, compares = 0, seed = 84, cyc = 0, i;
    logic [7:0] ops [0:15] = '{8'h38, 8'h3D, 8'h35, 8'h36, 8'h37, 8'h34, 8'h01, 8'h58,
                              8'h5F, 8'h55, 8'h56, 8'h57, 8'h54, 8'h52, 8'h53, 8'hA5};
    logic [7:0] op, r2;
    aaa_exec aaa_exec_inst (.clk(clk), .rst_b(rst_b), .clkEn(clkEn), .instrValid(instrValid),
        .opcode(opcode), .byte2(byte2), .byte3(byte3), .pcIn(pcIn), .accIn(accIn),
        .carryIn(carryIn), .workRegData(workRegData), .indirectPtrData(indirectPtrData),
        .directData(directData), .portLatchData(portLatchData), .directIsPort(directIsPort),
        .workingRegisterSel(workingRegisterSel), .indirectPointerReg(indirectPointerReg),
        .directAddr(directAddr), .accWe(accWe), .accOut(accOut), .flagWe(flagWe),
        .carryFlag(carryFlag), .auxCarryFlag(auxCarryFlag), .overflowFlag(overflowFlag),
        .parityFlag(parityFlag), .dirWe(dirWe), .dirWrAddr(dirWrAddr), .dirWrData(dirWrData),
        .pcWe(pcWe), .pcOut(pcOut), .done(done), .busy(busy), .illegal(illegal));
    aaa_data_model aaa_data_model_inst (.workingRegisterSel(workingRegisterSel),
        .indirectPointerReg(indirectPointerReg), .directAddr(directAddr),
        .workRegData(workRegData), .indirectPtrData(indirectPtrData), .directData(directData),
        .portLatchData(portLatchData), .directIsPort(directIsPort));
    // Clock and hang guard
    always #5 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            err_count = err_count + 1;
            test_done;
        end
    end
    // Counted comparison
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        begin
            compares = compares + 1;
            if (got !== exp) begin
                $display("[FAIL] %s expected %h seen %h", name, exp, got);
                err_count = err_count + 1;
            end
        end
    endtask
    task automatic test_done;
        begin
            $display("errors %0d compares %0d", err_count, compares);
            if (err_count == 0 && compares > 0) $display("RESULT: PASS");
            else $display("RESULT: FAIL");
            $finish;
        end
    endtask
    // Issue one instruction, wait for completion and check every result except accWe, dirWe and pcWe
    task automatic run(input logic [7:0] o, b2, b3, a, input logic [15:0] pc, input logic c);
        logic [8:0] s;
        logic [7:0] src, res;
        logic [15:0] t, nb;
        logic ac, c6, sawBusy;
        integer k;
        begin
            @(posedge clk);
            opcode <= o; byte2 <= b2; byte3 <= b3; accIn <= a; pcIn <= pc; carryIn <= c;
            instrValid <= 1'b1;
            @(posedge clk);
            instrValid <= 1'b0;
            sawBusy = 1'b0;
            k = 0;
            do begin
                @(negedge clk);
                if (busy === 1'b1) sawBusy = 1'b1;
                k = k + 1;
            end while (done !== 1'b1 && illegal !== 1'b1 && k < 4);
            src = o[3] ? workRegData : o[1] ? indirectPtrData : o[0] ? directData : b2;
            nb = (o[3] | o[1]) ? 16'h0001 : 16'h0002;
            t = pc + 16'h0002;
            if (o[4:0] == 5'h01) begin
                chk("jump pc", {t[15:11], o[7:5], b2}, pcOut);
                chk("jump busy", 16'h0001, sawBusy);
            end else if (o[7:3] == 5'b00111 || o[7:2] == 6'b001101) begin
                s = {1'b0, a} + {1'b0, src} + {8'h00, c};
                ac = ({1'b0, a[3:0]} + {1'b0, src[3:0]} + {4'h0, c}) > 5'h0F;
                c6 = ({1'b0, a[6:0]} + {1'b0, src[6:0]} + {7'h00, c}) > 8'h7F;
                chk("add acc", {8'h00, s[7:0]}, accOut);
                chk("add flags", {s[8], ac, 1'b1}, {carryFlag, auxCarryFlag, flagWe});
                chk("add ovf", c6 ^ s[8], overflowFlag);
                chk("add parity", ^s[7:0], parityFlag);
                chk("add pc", pc + nb, pcOut);
            end else if (o[7:3] == 5'b01011 || o[7:2] == 6'b010101) begin
                res = a & src;
                chk("and acc", {8'h00, res}, {7'h00, flagWe, accOut});
                chk("and parity", ^res, parityFlag);
                chk("and pc", pc + nb, pcOut);
            end else if (o == 8'h52 || o == 8'h53) begin
                res = (directIsPort ? portLatchData : directData) & (o[0] ? b3 : a);
                chk("and dir", {b2, res}, {dirWrAddr, dirWrData});
                chk("and dir busy", o[0], sawBusy);
                chk("and dir pc", pc + 16'h0002 + o[0], pcOut);
            end else begin
                chk("illegal", 16'h0001, illegal);
            end
            if (o != 8'hA5) chk("done", 16'h0001, done);
        end
    endtask
    // Main sequence
    initial begin
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        run(8'hE1, 8'h23, 8'h00, 8'h00, 16'h07FE, 1'b0);
        run(8'h34, 8'hFF, 8'h00, 8'h80, 16'h0100, 1'b1);
        run(8'h53, 8'h80, 8'h73, 8'h00, 16'h0200, 1'b0);
        run(8'h52, 8'h90, 8'h00, 8'h3C, 16'hFFFE, 1'b0);
        // Enable low must hold off an offered instruction
        @(posedge clk);
        clkEn <= 1'b0;
        opcode <= 8'h34;
        instrValid <= 1'b1;
        repeat (2) @(posedge clk);
        instrValid <= 1'b0;
        clkEn <= 1'b1;
        @(negedge clk);
        chk("frozen", 16'h0000, {accWe, done});
        for (i = 0; i < 300; i = i + 1) begin
            op = ops[$random(seed) & 15];
            r2 = 8'($random(seed));
            if (op == 8'h01) op[7:5] = r2[7:5];
            run(op, r2[0] ? 8'h80 : 8'($random(seed)), 8'($random(seed)), 8'($random(seed)),
                16'($random(seed)), r2[1]);
        end
        test_done;
    end
endmodule // aaa_exec_tb_top
`default_nettype wire
